// File: hdl/psym_defines.svh
/*
 * Constants of the 100 Mb/s symbol port: clock rates, divider counts,
 * reset values and buffer settings.
 * Assumes it is included by bare name from every file that needs it.
 */
`ifndef PSYM_DEFINES_SVH
`define PSYM_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock rates
// ----------------------------------------------------------------------
`define PSYM_CLK_MHZ 50
`define PSYM_SYMBOL_CLK_MHZ 25
`define PSYM_SYMBOL_HALF 4'(`PSYM_CLK_MHZ / (2 * `PSYM_SYMBOL_CLK_MHZ))

// ----------------------------------------------------------------------
// Widths, reset values and buffer settings
// ----------------------------------------------------------------------
`define PSYM_SYMBOL_WIDTH 5
`define PSYM_SYMBOL_MSB 4
`define PSYM_SYMBOL_RESET 5'h00
`define PSYM_ADDR_WIDTH 5
`define PSYM_ADDR_FLOAT 5'h00
`define PSYM_FIFO_DEPTH 16
`define PSYM_FILL_MARK 8

`endif

// File: hdl/psym_fifo.sv
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps

module psym_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH+1)-1:0] count
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic push;
    logic pop;

    // Pointer step with wrap, so depths other than powers of two work.
    function automatic logic [PW-1:0] stepPtr(input logic [PW-1:0] p);
        stepPtr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'h1);
    endfunction : stepPtr

    // ------------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------------
    // Full and empty come straight from the occupancy count.
    assign inReady = (count != CW'(DEPTH));
    assign outValid = (count != '0);
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = store[rdPtr];

    // Storage is written only on an accepted word.
    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr] <= inData;
        end
    end

    // Pointers and count move together.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= stepPtr(wrPtr);
            end
            if (pop) begin
                rdPtr <= stepPtr(rdPtr);
            end
            if (push && !pop) begin
                count <= CW'(count + 1'h1);
            end else if (pop && !push) begin
                count <= CW'(count - 1'h1);
            end
        end
    end

endmodule : psym_fifo

// File: hdl/psym_pkg.sv
/*
 * Types shared by the symbol port and its buffer.
 * Assumes psym_defines.svh is on the include path.
 */
`include "psym_defines.svh"

package psym_pkg;

    // Five-bit raw line symbol.
    typedef logic [`PSYM_SYMBOL_WIDTH-1:0] psym_symbol_t;

    // Receive presenter: prime the buffer, then stream for good.
    typedef enum {
        PSYM_PRIME,
        PSYM_STREAM
    } psym_rx_state_t;

endpackage : psym_pkg

// File: hdl/psym_symbol_port.sv
/*
 * 100 Mb/s raw symbol port of a PHY's MAC side. Line symbols arrive on
 * the recovered line clock, cross by handshake, wait in a FIFO and leave
 * on the receive symbol bus; transmit symbols are sampled on the driven
 * transmit symbol clock and handed to the core with a strobe.
 * Assumes clk runs at 50 MHz and lineClk is unrelated to it.
 */
`timescale 1ns/100ps
`include "psym_defines.svh"

module psym_symbol_port #(
    parameter int FIFO_DEPTH = `PSYM_FIFO_DEPTH,
    parameter int FILL_MARK = `PSYM_FILL_MARK
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic lineClk,
    input wire logic [4:0] lineSymbol,
    input wire logic lineValid,
    output logic lineReady,
    output logic rxSymbolClock,
    output logic [4:0] rxSymbolBus,
    output logic txSymbolClock,
    input wire logic [4:0] txSymbolBus,
    output logic macDriveN,
    input wire logic rxFloatRequest,
    input wire logic [4:0] phyAddress,
    output logic rxDataValid,
    output logic collision,
    output logic unusedDriveN,
    output logic [4:0] txSymbol,
    output logic txSymbolStrobe
);

    localparam int CW = $clog2(FIFO_DEPTH + 1);

    // Line domain.
    logic lineRst1;
    logic lineRst2;
    logic lineReq;
    psym_pkg::psym_symbol_t lineWord;
    logic lineAck1;
    logic lineAck2;

    // Core domain.
    logic reqSync1;
    logic reqSync2;
    logic coreAck;
    logic pending;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    psym_pkg::psym_symbol_t fifoOutData;
    logic [CW-1:0] fifoCount;
    logic [3:0] divCount;
    logic symPhase;
    logic riseNext;
    psym_pkg::psym_rx_state_t rxState;
    logic [4:0] txSync1;
    logic [4:0] txSync2;
    logic floatSync1;
    logic floatSync2;
    logic [4:0] addrSync1;
    logic [4:0] addrSync2;
    logic strapTaken;
    logic addrZero;

    // A toggle that differs from its partner marks a pending transfer.
    function automatic logic toggled(input logic a, input logic b);
        toggled = (a != b);
    endfunction : toggled

    // ------------------------------------------------------------------
    // Line clock domain
    // ------------------------------------------------------------------
    // Reset reaches the line domain through two flops.
    always_ff @(posedge lineClk) begin
        lineRst1 <= rstn;
        lineRst2 <= lineRst1;
    end

    // The core acknowledge toggle is brought over by two flops.
    always_ff @(posedge lineClk) begin
        lineAck1 <= coreAck;
        lineAck2 <= lineAck1;
    end

    // Ready stays low while a word is in flight; the source must hold.
    assign lineReady = !toggled(lineReq, lineAck2);

    // A word is held stable in lineWord until the core acknowledges it,
    // which is what makes reading it from the core domain safe.
    always_ff @(posedge lineClk) begin
        if (!lineRst2) begin
            lineReq <= 1'h0;
            lineWord <= `PSYM_SYMBOL_RESET;
        end else if (lineValid && lineReady) begin
            lineWord <= lineSymbol;
            lineReq <= ~lineReq;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into the core domain
    // ------------------------------------------------------------------
    // Request toggle synchroniser.
    always_ff @(posedge clk) begin
        reqSync1 <= lineReq;
        reqSync2 <= reqSync1;
    end

    assign pending = toggled(reqSync2, coreAck);

    // Acknowledge only once the FIFO took the word, so a full buffer
    // pushes back all the way to the line source.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            coreAck <= 1'h0;
        end else if (pending && fifoInReady) begin
            coreAck <= ~coreAck;
        end
    end

    psym_fifo #(
        .WIDTH(`PSYM_SYMBOL_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .inValid(pending),
        .inReady(fifoInReady),
        .inData(lineWord),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData),
        .count(fifoCount)
    );

    // ------------------------------------------------------------------
    // Symbol clock divider
    // ------------------------------------------------------------------
    // Both symbol clocks come from one flop, so they share every edge.
    assign riseNext = !symPhase && (divCount == `PSYM_SYMBOL_HALF - 4'h1);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            divCount <= 4'h0;
            symPhase <= 1'h0;
        end else if (divCount == `PSYM_SYMBOL_HALF - 4'h1) begin
            divCount <= 4'h0;
            symPhase <= ~symPhase;
        end else begin
            divCount <= divCount + 4'h1;
        end
    end

    assign rxSymbolClock = symPhase;
    assign txSymbolClock = symPhase;

    // ------------------------------------------------------------------
    // Receive presenter
    // ------------------------------------------------------------------
    // Priming half fills the buffer so line jitter does not starve it.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rxState <= psym_pkg::PSYM_PRIME;
        end else begin
            unique case (rxState)
                psym_pkg::PSYM_PRIME: begin
                    if (int'(fifoCount) >= FILL_MARK) begin
                        rxState <= psym_pkg::PSYM_STREAM;
                    end
                end
                psym_pkg::PSYM_STREAM: begin
                    rxState <= psym_pkg::PSYM_STREAM;
                end
            endcase
        end
    end

    assign fifoOutReady = (rxState == psym_pkg::PSYM_STREAM) && riseNext;

    // One symbol per rising edge, bit for bit and unframed. On underflow
    // the last symbol repeats; the MAC sees no gap marker.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rxSymbolBus <= `PSYM_SYMBOL_RESET;
        end else if (fifoOutReady && fifoOutValid) begin
            rxSymbolBus <= fifoOutData;
        end
    end

    // Valid and collision stay low and undriven in this mode.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rxDataValid <= 1'h0;
            collision <= 1'h0;
            unusedDriveN <= 1'h1;
        end else begin
            rxDataValid <= 1'h0;
            collision <= 1'h0;
            unusedDriveN <= 1'h1;
        end
    end

    // ------------------------------------------------------------------
    // Transmit sampling
    // ------------------------------------------------------------------
    // Pin synchroniser; this costs two clk cycles of latency, which the
    // 40 ns symbol period comfortably absorbs.
    always_ff @(posedge clk) begin
        txSync1 <= txSymbolBus;
        txSync2 <= txSync1;
    end

    // Every rising edge takes a symbol; there is no enable to wait for,
    // so the partner must fill idle time with idle symbols itself.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            txSymbol <= `PSYM_SYMBOL_RESET;
            txSymbolStrobe <= 1'h0;
        end else begin
            txSymbolStrobe <= riseNext;
            if (riseNext) begin
                txSymbol <= txSync2;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output float control
    // ------------------------------------------------------------------
    // Float request and address straps pass two flops first.
    always_ff @(posedge clk) begin
        floatSync1 <= rxFloatRequest;
        floatSync2 <= floatSync1;
        addrSync1 <= phyAddress;
        addrSync2 <= addrSync1;
    end

    // The address strap is caught once, after reset has settled the
    // synchroniser, and then held until the next reset.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            strapTaken <= 1'h0;
            addrZero <= 1'h1;
        end else if (!strapTaken) begin
            strapTaken <= 1'h1;
            addrZero <= (addrSync2 == `PSYM_ADDR_FLOAT);
        end
    end

    // Outputs stay released through reset and until the strap is known.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            macDriveN <= 1'h1;
        end else begin
            macDriveN <= floatSync2 || addrZero || !strapTaken;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_clock_period;
        !rxSymbolClock ##1 rxSymbolClock;
    endsequence

    sequence s_strobe_gap;
        !txSymbolStrobe ##1 txSymbolStrobe;
    endsequence

    a_rx_clock_rate: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rxSymbolClock) |=> s_clock_period)
        else $error("Receive symbol clock is not at half the core rate.");

    a_tx_clock_same: assert property (@(posedge clk) disable iff (!rstn)
        txSymbolClock == rxSymbolClock)
        else $error("Transmit symbol clock departs from receive clock.");

    a_rx_bus_order: assert property (@(posedge clk) disable iff (!rstn)
        fifoOutReady && fifoOutValid |=> rxSymbolBus == $past(fifoOutData))
        else $error("Receive symbol does not match buffered symbol.");

    a_rx_msb_lane: assert property (@(posedge clk) disable iff (!rstn)
        fifoOutReady && fifoOutValid
        |=> rxSymbolBus[`PSYM_SYMBOL_MSB] == $past(fifoOutData[4]))
        else $error("Receive symbol top bit is on the wrong lane.");

    a_rx_edge_only: assert property (@(posedge clk) disable iff (!rstn)
        $changed(rxSymbolBus) |-> $rose(rxSymbolClock))
        else $error("Receive symbol changed away from a rising edge.");

    a_rx_no_frame: assert property (@(posedge clk) disable iff (!rstn)
        rxDataValid == 1'h0 && unusedDriveN && !collision)
        else $error("Valid or collision asserted in symbol mode.");

    a_tx_sample_rise: assert property (@(posedge clk) disable iff (!rstn)
        $rose(txSymbolClock) |-> txSymbolStrobe ##1 s_strobe_gap)
        else $error("Transmit symbol not sampled on every rising edge.");

    a_tx_value_kept: assert property (@(posedge clk) disable iff (!rstn)
        txSymbolStrobe |-> txSymbol == $past(txSync2))
        else $error("Transmit symbol differs from the sampled pins.");

    a_float_request: assert property (@(posedge clk) disable iff (!rstn)
        floatSync2 |=> macDriveN)
        else $error("Outputs driven while the float request is high.");

    a_float_address: assert property (@(posedge clk) disable iff (!rstn)
        strapTaken && addrZero |=> macDriveN [*2])
        else $error("Outputs driven although the port address is zero.");

    a_drive_normal: assert property (@(posedge clk) disable iff (!rstn)
        strapTaken && !addrZero && !floatSync2 |=> !macDriveN)
        else $error("Outputs float without any float cause.");

    a_line_hold: assert property (@(posedge lineClk) disable iff (!lineRst2)
        !lineReady |=> $stable(lineWord))
        else $error("Line word changed while a transfer was pending.");

    a_prime_hold: assert property (@(posedge clk) disable iff (!rstn)
        rxState == psym_pkg::PSYM_PRIME |-> !fifoOutReady)
        else $error("Buffer drained before priming finished.");

    // An empty buffer at a symbol edge leaves the last symbol standing.
    a_rx_dry: assert property (@(posedge clk) disable iff (!rstn)
        fifoOutReady && !fifoOutValid |=> $stable(rxSymbolBus))
        else $error("Receive symbol moved while the buffer was empty.");

    a_line_busy: assert property (@(posedge lineClk) disable iff (!lineRst2)
        lineValid && lineReady |=> !lineReady)
        else $error("Line ready stayed high after a symbol was taken.");

endmodule : psym_symbol_port

// File: verif/psym_mac_model.sv
/*
 * MAC-side partner of the symbol port: sends raw transmit symbols and
 * records the receive symbols that it sees.
 * Assumes the port drives both symbol clocks and the drive enable.
 */
`timescale 1ns/100ps

module psym_mac_model (
    input wire logic rxSymbolClock,
    input wire logic [4:0] rxSymbolBus,
    input wire logic txSymbolClock,
    input wire logic macDriveN,
    input wire logic sendBurst,
    output logic [4:0] txSymbolBus
);
    // ------------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------------
    localparam logic [4:0] IDLE_SYM = 5'h1F;
    int idx = 32;
    logic [4:0] rxLast = 5'h00;
    logic [4:0] rxSeen[$];
    int badChange = 0;
    realtime tRise = 0;

    initial txSymbolBus = IDLE_SYM;

    // A symbol stands for a whole clock period; idles fill the gaps,
    // because the port inserts none of its own.
    always @(negedge txSymbolClock) begin
        if (idx < 32) begin
            txSymbolBus <= 5'(idx);
            idx <= idx + 1;
        end else begin
            txSymbolBus <= IDLE_SYM;
            if (sendBurst) begin
                idx <= 0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------------
    // Sampled mid-period, since the bus moves on the rising edge.
    always @(negedge rxSymbolClock) begin
        if (!macDriveN && rxSymbolBus !== rxLast) begin
            rxSeen.push_back(rxSymbolBus);
            rxLast = rxSymbolBus;
        end
    end

    // A bus change away from a rising clock edge is counted as bad.
    always @(posedge rxSymbolClock) tRise = $realtime;
    always @(rxSymbolBus) begin
        #1;
        if (!macDriveN && $realtime - tRise > 1.5) begin
            badChange++;
        end
    end
endmodule : psym_mac_model

// File: verif/psym_symbol_port_bench.sv
/*
 * Bench of the symbol port with a line source and the MAC model; the
 * buffer is exercised through the port itself.
 * Assumes the hdl/ files and the MAC model are compiled before it.
 */
`timescale 1ns/100ps
`include "psym_defines.svh"

module psym_symbol_port_bench;
    logic clk = 1'b0;
    logic lineClk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] lineSymbol = 5'h00;
    logic lineValid = 1'b0;
    logic rxFloatRequest = 1'b0;
    logic [4:0] phyAddress = 5'h00;
    logic sendBurst = 1'b0;
    logic [4:0] txSymbolBus, rxSymbolBus, txSymbol;
    logic lineReady, rxSymbolClock, txSymbolClock, macDriveN;
    logic rxDataValid, collision, unusedDriveN, txSymbolStrobe;
    int miscompares = 0;
    int nChecks = 0;

    // ------------------------------------------------------------------
    // Clocks and instances
    // ------------------------------------------------------------------
    // The line clock starts off phase so no edge lines up with clk.
    always #10 clk = ~clk;
    initial begin
        #3;
        forever #16 lineClk = ~lineClk;
    end

    psym_symbol_port uut (.clk(clk), .rstn(rstn), .lineClk(lineClk),
        .lineSymbol(lineSymbol), .lineValid(lineValid),
        .lineReady(lineReady), .rxSymbolClock(rxSymbolClock),
        .rxSymbolBus(rxSymbolBus), .txSymbolClock(txSymbolClock),
        .txSymbolBus(txSymbolBus), .macDriveN(macDriveN),
        .rxFloatRequest(rxFloatRequest), .phyAddress(phyAddress),
        .rxDataValid(rxDataValid), .collision(collision),
        .unusedDriveN(unusedDriveN), .txSymbol(txSymbol),
        .txSymbolStrobe(txSymbolStrobe));

    psym_mac_model mac (.rxSymbolClock(rxSymbolClock),
        .rxSymbolBus(rxSymbolBus), .txSymbolClock(txSymbolClock),
        .macDriveN(macDriveN), .sendBurst(sendBurst),
        .txSymbolBus(txSymbolBus));

    // ------------------------------------------------------------------
    // Compare, report and bus tasks
    // ------------------------------------------------------------------
    task automatic check_sym(input string what, input logic [4:0] exp,
        input logic [4:0] got);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_sym

    task automatic check_int(input string what, input int exp,
        input int got);
        nChecks++;
        if (got != exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_int

    task automatic final_report();
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task automatic do_reset(input logic [4:0] addr);
        @(posedge clk);
        rstn <= 1'b0;
        phyAddress <= addr;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : do_reset

    // Holds the symbol until a settled ready is seen before an edge; the
    // released data shows its inverse so stale values never look valid.
    task automatic line_send(input logic [4:0] sym);
        int n = 0;
        @(posedge lineClk);
        lineValid <= 1'b1;
        lineSymbol <= sym;
        do begin
            @(negedge lineClk);
            n++;
        end while (lineReady !== 1'b1 && n < 200);
        @(posedge lineClk);
        lineValid <= 1'b0;
        lineSymbol <= ~sym;
        check_int("line handshake waits bounded", 1,
            int'(n < 200));
    endtask : line_send

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_float();
        do_reset(5'h00);
        #1 check_sym("enable at address zero", 5'h01, {4'h0, macDriveN});
        check_sym("unused pins", 5'h08, {collision, unusedDriveN, 3'h0});
        check_sym("valid pin", 5'h00, {4'h0, rxDataValid});
        do_reset(5'h01);
        #1 check_sym("enable when driving", 5'h00, {4'h0, macDriveN});
        @(posedge clk) rxFloatRequest <= 1'b1;
        repeat (6) @(posedge clk);
        #1 check_sym("enable on float", 5'h01, {4'h0, macDriveN});
        @(posedge clk) rxFloatRequest <= 1'b0;
        repeat (6) @(posedge clk);
        #1 check_sym("enable after float", 5'h00, {4'h0, macDriveN});
        $display("test float done");
    endtask : test_float

    task automatic test_clocks();
        realtime t0;
        @(posedge rxSymbolClock) t0 = $realtime;
        @(posedge rxSymbolClock);
        check_int("rx clock ns", 1000 / `PSYM_SYMBOL_CLK_MHZ,
            int'($realtime - t0));
        @(posedge txSymbolClock) t0 = $realtime;
        @(posedge txSymbolClock);
        check_int("tx clock ns", 1000 / `PSYM_SYMBOL_CLK_MHZ,
            int'($realtime - t0));
        $display("test clocks done");
    endtask : test_clocks

    task automatic test_tx();
        logic [4:0] seen[$];
        logic [4:0] got;
        int strobes = 0;
        int first = 0;
        bit found = 0;
        @(posedge clk) sendBurst <= 1'b1;
        repeat (2) @(posedge clk);
        sendBurst <= 1'b0;
        repeat (120) begin
            @(posedge clk);
            #1;
            if (txSymbolStrobe === 1'b1) begin
                strobes++;
                seen.push_back(txSymbol);
            end
        end
        check_int("tx strobes in 120 clk", 60, strobes);
        foreach (seen[i]) begin
            if (!found && seen[i] === 5'h00) begin
                first = i;
                found = 1;
            end
        end
        for (int i = 0; i < 32; i++) begin
            got = (first + i < seen.size()) ? seen[first + i] : 5'hX;
            check_sym("tx symbol", 5'(i), got);
        end
        $display("test tx done");
    endtask : test_tx

    task automatic test_rx();
        mac.rxSeen.delete();
        mac.badChange = 0;
        for (int i = 0; i < 16; i++) begin
            line_send(5'(i * 7 + 3));
        end
        repeat (60) @(posedge clk);
        check_int("rx symbols seen", 16, mac.rxSeen.size());
        for (int i = 0; i < 16 && i < mac.rxSeen.size(); i++) begin
            check_sym("rx symbol", 5'(i * 7 + 3), mac.rxSeen[i]);
        end
        check_int("off-edge bus changes", 0, mac.badChange);
        #1 check_sym("valid pin", 5'h00, {4'h0, rxDataValid});
        $display("test rx done");
    endtask : test_rx

    // Priming holds the bus at its reset value until the fill mark is
    // reached; then the symbols drain in order and, once the buffer runs
    // dry, the last one stands because no idle is inserted.
    task automatic test_fifo();
        int last = (`PSYM_FILL_MARK - 1) * 5 + 1;
        do_reset(5'h01);
        mac.rxSeen.delete();
        mac.rxLast = 5'h00;
        for (int i = 0; i < `PSYM_FILL_MARK - 1; i++) begin
            line_send(5'(i * 5 + 1));
        end
        repeat (20) @(posedge clk);
        #1 check_sym("bus while priming", `PSYM_SYMBOL_RESET,
            rxSymbolBus);
        line_send(5'(last));
        repeat (40) @(posedge clk);
        check_int("buffer symbols out", `PSYM_FILL_MARK,
            mac.rxSeen.size());
        foreach (mac.rxSeen[i]) begin
            check_sym("buffer head", 5'(i * 5 + 1), mac.rxSeen[i]);
        end
        #1 check_sym("bus on underflow", 5'(last), rxSymbolBus);
        $display("test fifo done");
    endtask : test_fifo

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        test_float();
        test_clocks();
        test_tx();
        test_rx();
        test_fifo();
        final_report();
    end

    // The tests need about 10 us; a hang is cut off well beyond that.
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
endmodule : psym_symbol_port_bench
